// ### hdl/dsr_pkg.sv
// Purpose: Shared constants and carriers of the status and alarm reporter.
// Assumes: One 100 MHz clock; registers reached over APB with 32-bit data.
// Notes:   Alarm vectors hold six bytes in latched-response order.
package dsr_pkg;

    localparam int CLK_MHZ = 100;

    // APB register byte offsets.
    localparam logic [7:0] OFS_CMD   = 8'h00;
    localparam logic [7:0] OFS_STAT  = 8'h04;
    localparam logic [7:0] OFS_DATA  = 8'h08;
    localparam logic [7:0] OFS_CLR   = 8'h0c;
    localparam logic [7:0] OFS_CTRL  = 8'h10;
    localparam logic [7:0] OFS_LIVE  = 8'h14;

    // Query opcodes.
    localparam logic [15:0] OP_LATCHED = 16'h2406;
    localparam logic [15:0] OP_CURRENT = 16'h2409;
    // Status query opcode; the value is arbitrary.
    localparam logic [15:0] OP_STATUS  = 16'h2400;

    // Response lengths in bytes.
    localparam logic [7:0] LEN_STATUS  = 8'h59;
    localparam logic [7:0] LEN_LATCHED = 8'h06;
    localparam logic [7:0] LEN_CURRENT = 8'h07;
    localparam int         STORE_BYTES = 12;

    // Status and control register fields.
    localparam int STAT_VALID_BIT = 0;
    localparam int STAT_ERR_BIT   = 1;
    localparam int STAT_LEN_LSB   = 8;
    localparam int STAT_PTR_LSB   = 16;
    localparam int CTRL_LEGACY_BIT = 0;

    // Reset values.
    localparam logic [15:0] CMD_RST  = 16'h0000;
    localparam logic        CTRL_RST = 1'b0;

    localparam logic [7:0] BUF_PCT_MAX = 8'h64;

    // Per-bit masks, bytes ordered a1, a2, a3, c1, c2, a4.
    localparam logic [47:0] LATCH_MASK  = 48'h7f_ff_87_37_07_0c;
    localparam logic [47:0] CUR_INVERT  = 48'h40_00_ff_00_06_3f;
    localparam logic [47:0] LEGACY_ZERO = 48'h00_00_00_00_02_32;

    // Fault sources, each bit one means failure.
    typedef struct packed {
        logic [7:0] a1;
        logic [7:0] a2;
        logic [7:0] a3;
        logic [7:0] c1;
        logic [7:0] c2;
        logic [7:0] a4;
    } dsr_alarm_s;

    typedef struct packed {
        logic        ber_valid;
        logic        tp_ber_valid;
        logic [1:0]  ebno_qual;
        logic        ber_ovf;
        logic        tp_ber_ovf;
        logic [7:0]  buf_pct;
        logic [7:0]  in_level;
        logic [7:0]  ins_fault;
        logic        online;
        logic        insert_data_input_loss;
        logic        trellis_lock;
        logic        fm_lock;
        logic        t1_sig_fail;
        logic        turbo_fail;
        logic [31:0] sym_rate;
    } dsr_status_s;

endpackage

// ### hdl/dsr_sync.sv
// Purpose: Two-stage synchroniser for a vector of pin levels.
// Assumes: Bits are independent levels; no word coherence is needed.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
module dsr_sync #(
    parameter int W = 48
) (
    input  wire logic         clk_in,   // System clock.
    input  wire logic         rstn_in,  // Asynchronous reset, active low.
    input  wire logic         ce_in,    // Clock enable.
    input  wire logic [W-1:0] d_in,     // Asynchronous levels.
    output logic      [W-1:0] q_out     // Synchronised levels.
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_r <= '0;
            q_out  <= '0;
        end else if (ce_in) begin
            meta_r <= d_in;
            q_out  <= meta_r;
        end
    end
endmodule // dsr_sync

// ### hdl/dsr_sticky.sv
// Purpose: Per-bit sticky fault latches.
// Assumes: Set and clear are one-cycle or level terms on the same clock.
// Notes:   A set in the clearing cycle keeps the bit set.
`timescale 1ns/1ps
module dsr_sticky #(
    parameter int W = 48
) (
    input  wire logic         clk_in,   // System clock.
    input  wire logic         rstn_in,  // Asynchronous reset, active low.
    input  wire logic         ce_in,    // Clock enable.
    input  wire logic [W-1:0] set_in,   // Failure seen this cycle.
    input  wire logic [W-1:0] clr_in,   // Host clear pulse.
    output logic      [W-1:0] q_out     // Held failures.
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge clk_in or negedge rstn_in) begin
                if (!rstn_in) begin
                    q_out[i] <= 1'b0;
                end else if (ce_in) begin
                    q_out[i] <= set_in[i] | (q_out[i] & ~clr_in[i]);
                end
            end
        end
    endgenerate
endmodule // dsr_sticky

// ### hdl/dsr_reporter.sv
// Purpose: Builds status, latched-alarm and current-alarm responses.
// Assumes: Status fields come from logic on clk_in; fault pins do not.
// Notes:   A command write snapshots one response; bytes are popped
//          one at a time from the data register, most significant first.
//          Fault pins reach the responses two cycles after they change; latched bits take three.
//
// Overview of operation
// - Bits 0,1 flag BER and test BER valid.
// - Bits 2-3 give Eb/No quality code.
// - Bits 4,5 flag counter overflows; 6-7 reserved.
// - Buffer fill byte, percent 0 to 100.
// - Input level byte in 1 dB steps.
// - Insert framing lock faults in bits 0-2.
// - Insert bits 3-7: received alarms, CRC error.
// - Online byte: 0 offline, 1 online.
// - Loss byte is 1 on input loss.
// - Alarm 5: locks, signaling and turbo faults.
// - Four-byte symbol rate, then 77 reserved bytes.
// - Latched query returns latched bytes in order.
// - Latch alarm 1 bits 0-6; AGC passes.
// - Latch all bits of alarm 2.
// - Latch synth and PLL faults; decoder locks pass.
// - Alarm 4 latches only clock activity bits 2,3.
// - Latch common 2 bits 0-2; rest spare.
// - Current query returns live state, lock as 1.
`timescale 1ns/1ps
module dsr_reporter (
    input  wire logic                clk_in,       // System clock.
    input  wire logic                rstn_in,      // Async reset, low.
    input  wire logic                ce_in,        // Clock enable.
    input  wire logic                psel_in,      // APB select.
    input  wire logic                penable_in,   // APB enable.
    input  wire logic                pwrite_in,    // APB write.
    input  wire logic [7:0]          paddr_in,     // APB byte address.
    input  wire logic [31:0]         pwdata_in,    // APB write data.
    input  wire dsr_pkg::dsr_status_s status_in,   // Same-clock status.
    input  wire dsr_pkg::dsr_alarm_s  fault_pin_in, // Fault pins.
    output logic [31:0]              prdata_out,   // APB read data.
    output logic                     pready_out,   // APB ready.
    output logic                     pslverr_out   // APB error.
);
    dsr_pkg::dsr_alarm_s fault_s;
    dsr_pkg::dsr_alarm_s held_s;
    logic [47:0]         clr_vec;
    logic [47:0]         latched_vec;
    logic [47:0]         current_vec;

    logic [15:0]         cmd_r;
    logic                legacy_r;
    logic                resp_valid_r;
    logic                cmd_err_r;
    logic [7:0]          resp_len_r;
    logic [7:0]          rd_ptr_r;
    logic [7:0]          resp_mem_r [dsr_pkg::STORE_BYTES];
    logic [7:0]          resp_nxt   [dsr_pkg::STORE_BYTES];
    logic [7:0]          len_nxt;
    logic                cmd_ok;

    logic                setup_ph;
    logic                access_ph;
    logic                wr_cmd;
    logic                wr_clr;
    logic                wr_ctrl;
    logic                rd_data;
    logic                mapped;
    logic [31:0]         rdata_nxt;
    logic [7:0]          pop_byte;

    // Fault pins are asynchronous; a failure shorter than a clock period
    // may be missed, so sources must hold a failure at least that long.
    dsr_sync #(
        .W (48)
    ) u_sync (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .ce_in   (ce_in),
        .d_in    (fault_pin_in),
        .q_out   (fault_s)
    );

    // Only masked bits reach the latches, so live bits never stick.
    dsr_sticky #(
        .W (48)
    ) u_sticky (
        .clk_in  (clk_in),
        .rstn_in (rstn_in),
        .ce_in   (ce_in),
        .set_in  (fault_s & dsr_pkg::LATCH_MASK),
        .clr_in  (clr_vec),
        .q_out   (held_s)
    );

    // Host clear: write bit k to clear response byte k of the latched set.
    genvar k;
    generate
        for (k = 0; k < 6; k++) begin : g_clr
            assign clr_vec[47-8*k -: 8] =
                {8{wr_clr & pwdata_in[k]}};
        end
    endgenerate

    // Latched bytes keep held bits and pass the rest live.
    // Legacy mode only masks bits on the way out; the latches keep
    // running, so leaving it shows faults that happened meanwhile.
    assign latched_vec = ((held_s & dsr_pkg::LATCH_MASK) |
                          (fault_s & ~dsr_pkg::LATCH_MASK)) &
                         ~({48{legacy_r}} & dsr_pkg::LEGACY_ZERO);

    // Live bytes report lock, activity and presence as one.
    assign current_vec = (fault_s ^ dsr_pkg::CUR_INVERT) &
                         ~({48{legacy_r}} & dsr_pkg::LEGACY_ZERO);

    // APB phase decode.
    // Actions take place on the access edge, when ready is high.
    assign setup_ph  = psel_in & ~penable_in;
    assign access_ph = psel_in & penable_in & pready_out;
    assign wr_cmd  = access_ph & pwrite_in & (paddr_in == dsr_pkg::OFS_CMD);
    assign wr_clr  = access_ph & pwrite_in & (paddr_in == dsr_pkg::OFS_CLR);
    assign wr_ctrl = access_ph & pwrite_in & (paddr_in == dsr_pkg::OFS_CTRL);
    assign rd_data = access_ph & ~pwrite_in &
                     (paddr_in == dsr_pkg::OFS_DATA);

    // Only these offsets answer; any other is refused with pslverr.
    always_comb begin
        unique case (paddr_in)
            dsr_pkg::OFS_CMD, dsr_pkg::OFS_STAT, dsr_pkg::OFS_DATA,
            dsr_pkg::OFS_CLR, dsr_pkg::OFS_CTRL,
            dsr_pkg::OFS_LIVE: mapped = 1'b1;
            default:           mapped = 1'b0;
        endcase
    end

    // Bytes past the stored part are reserved and read as zero.
    always_comb begin
        if (rd_ptr_r < 8'(dsr_pkg::STORE_BYTES)) begin
            pop_byte = resp_mem_r[rd_ptr_r[3:0]];
        end else begin
            pop_byte = 8'h00;
        end
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        unique case (paddr_in)
            dsr_pkg::OFS_CMD: begin
                rdata_nxt[15:0] = cmd_r;
            end
            dsr_pkg::OFS_STAT: begin
                rdata_nxt[dsr_pkg::STAT_VALID_BIT] = resp_valid_r;
                rdata_nxt[dsr_pkg::STAT_ERR_BIT]   = cmd_err_r;
                rdata_nxt[dsr_pkg::STAT_LEN_LSB +: 8] = resp_len_r;
                rdata_nxt[dsr_pkg::STAT_PTR_LSB +: 8] = rd_ptr_r;
            end
            dsr_pkg::OFS_DATA: begin
                if (resp_valid_r) begin
                    rdata_nxt[7:0] = pop_byte;
                end
            end
            dsr_pkg::OFS_CTRL: begin
                rdata_nxt[dsr_pkg::CTRL_LEGACY_BIT] = legacy_r;
            end
            dsr_pkg::OFS_LIVE: begin
                rdata_nxt[7:0] = latched_vec[47:40];
            end
            default: begin
                rdata_nxt = 32'h0000_0000;
            end
        endcase
    end

    // Response assembly for the opcode being written.
    always_comb begin
        for (int i = 0; i < dsr_pkg::STORE_BYTES; i++) begin
            resp_nxt[i] = 8'h00;
        end
        len_nxt = 8'h00;
        cmd_ok  = 1'b1;
        unique case (pwdata_in[15:0])
            dsr_pkg::OP_STATUS: begin
                len_nxt = dsr_pkg::LEN_STATUS;
                resp_nxt[0] = {2'b00,
                               status_in.tp_ber_ovf,
                               status_in.ber_ovf,
                               status_in.ebno_qual,
                               status_in.tp_ber_valid,
                               status_in.ber_valid};
                resp_nxt[1] = (status_in.buf_pct > dsr_pkg::BUF_PCT_MAX) ?
                              dsr_pkg::BUF_PCT_MAX :
                              status_in.buf_pct;
                resp_nxt[2] = status_in.in_level;
                resp_nxt[3] = status_in.ins_fault;
                resp_nxt[4] = {7'h00, status_in.online};
                resp_nxt[5] = {7'h00,
                               status_in.insert_data_input_loss};
                resp_nxt[6] = {4'h0,
                               status_in.turbo_fail,
                               status_in.t1_sig_fail,
                               status_in.fm_lock,
                               status_in.trellis_lock};
                // Alarm 4 rides along so one status poll shows it.
                resp_nxt[7] = latched_vec[7:0];
                resp_nxt[8]  = status_in.sym_rate[31:24];
                resp_nxt[9]  = status_in.sym_rate[23:16];
                resp_nxt[10] = status_in.sym_rate[15:8];
                resp_nxt[11] = status_in.sym_rate[7:0];
            end
            dsr_pkg::OP_LATCHED: begin
                len_nxt = dsr_pkg::LEN_LATCHED;
                for (int i = 0; i < 6; i++) begin
                    resp_nxt[i] = latched_vec[47-8*i -: 8];
                end
            end
            // Alarm 4 and the insert byte come before the common bytes.
            dsr_pkg::OP_CURRENT: begin
                len_nxt = dsr_pkg::LEN_CURRENT;
                resp_nxt[0] = current_vec[47:40];
                resp_nxt[1] = current_vec[39:32];
                resp_nxt[2] = current_vec[31:24];
                resp_nxt[3] = current_vec[7:0];
                resp_nxt[4] = status_in.ins_fault;
                resp_nxt[5] = current_vec[23:16];
                resp_nxt[6] = current_vec[15:8];
            end
            default: begin
                cmd_ok = 1'b0;
            end
        endcase
    end

    // Answers are prepared in the setup cycle so the access cycle is
    // never stretched; ready drops after each access.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else if (ce_in) begin
            pready_out  <= setup_ph;
            pslverr_out <= setup_ph & ~mapped;
        end
    end

    // Read data is captured once per read setup and then held; any
    // unmapped access, write or read, shows zero with its error.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            prdata_out <= 32'h0000_0000;
        end else if (ce_in && setup_ph && (!pwrite_in || !mapped)) begin
            prdata_out <= rdata_nxt;
        end
    end

    // Legacy mode applies to the next snapshot and to live reads.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            legacy_r <= dsr_pkg::CTRL_RST;
        end else if (ce_in && wr_ctrl) begin
            legacy_r <= pwdata_in[dsr_pkg::CTRL_LEGACY_BIT];
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            cmd_r     <= dsr_pkg::CMD_RST;
            cmd_err_r <= 1'b0;
        end else if (ce_in && wr_cmd) begin
            cmd_r     <= pwdata_in[15:0];
            cmd_err_r <= ~cmd_ok;
        end
    end

    // A new command replaces any response not yet read out. The pointer
    // stops once the response is drained, so later reads return zero.
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            resp_valid_r <= 1'b0;
            resp_len_r   <= 8'h00;
            rd_ptr_r     <= 8'h00;
        end else if (ce_in) begin
            if (wr_cmd) begin
                resp_valid_r <= cmd_ok;
                resp_len_r   <= len_nxt;
                rd_ptr_r     <= 8'h00;
            end else if (rd_data && resp_valid_r) begin
                rd_ptr_r <= rd_ptr_r + 8'h01;
                if (rd_ptr_r + 8'h01 == resp_len_r) begin
                    resp_valid_r <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            for (int i = 0; i < dsr_pkg::STORE_BYTES; i++) begin
                resp_mem_r[i] <= 8'h00;
            end
        end else if (ce_in && wr_cmd && cmd_ok) begin
            for (int i = 0; i < dsr_pkg::STORE_BYTES; i++) begin
                resp_mem_r[i] <= resp_nxt[i];
            end
        end
    end
endmodule // dsr_reporter

// ### tb/dsr_reporter_checker.sv
// Purpose: Assertions on the reporter's APB port and response bytes.
// Assumes: The bench holds ce_in high and moves fault pins slowly.
// Notes:   Response bytes are tracked by counting data reads.
`timescale 1ns/1ps
module dsr_reporter_checker (
    input wire logic                 clk_in,       // Clock.
    input wire logic                 rstn_in,      // Reset, low.
    input wire logic                 ce_in,        // Enable.
    input wire logic                 psel_in,      // Select.
    input wire logic                 penable_in,   // Access phase.
    input wire logic                 pwrite_in,    // Write.
    input wire logic [7:0]           paddr_in,     // Address.
    input wire logic [31:0]          pwdata_in,    // Write data.
    input wire dsr_pkg::dsr_status_s status_in,    // Status.
    input wire dsr_pkg::dsr_alarm_s  fault_pin_in, // Fault pins.
    input wire logic [31:0]          prdata_out,   // Read data.
    input wire logic                 pready_out,   // Ready.
    input wire logic                 pslverr_out   // Error.
);
    logic                 ack;
    logic                 mapped;
    logic                 sd;
    logic                 lv;
    logic [15:0]          op_r;
    logic [7:0]           ptr_r;
    logic [6:0]           held_r;
    logic [95:0]          exp;
    dsr_pkg::dsr_status_s s_r;
    assign ack = psel_in && penable_in && pready_out && !pwrite_in;
    assign mapped = paddr_in[1:0] == 2'b00 && paddr_in <= 8'h14;
    assign sd = ack && paddr_in == dsr_pkg::OFS_DATA
                && op_r == dsr_pkg::OP_STATUS;
    assign lv = ack && paddr_in == dsr_pkg::OFS_LIVE;
    // Byte 7 carries latched alarms and is left to the bench.
    assign exp = {2'b00, s_r.tp_ber_ovf, s_r.ber_ovf, s_r.ebno_qual,
                  s_r.tp_ber_valid, s_r.ber_valid,
                  (s_r.buf_pct > 8'h64) ? 8'h64 : s_r.buf_pct,
                  s_r.in_level, s_r.ins_fault, 7'h00, s_r.online, 7'h00,
                  s_r.insert_data_input_loss, 4'h0, s_r.turbo_fail,
                  s_r.t1_sig_fail, s_r.fm_lock, s_r.trellis_lock, 8'h00,
                  s_r.sym_rate};
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            op_r  <= 16'h0000;
            ptr_r <= 8'h00;
            s_r   <= '0;
        end else if (psel_in && penable_in && pready_out && pwrite_in
                     && paddr_in == dsr_pkg::OFS_CMD) begin
            op_r  <= pwdata_in[15:0];
            ptr_r <= 8'h00;
            s_r   <= status_in;
        end else if (sd && ptr_r != 8'hff) begin
            ptr_r <= ptr_r + 8'h01;
        end
    end
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            held_r <= 7'h00;
        end else if (psel_in && penable_in && pready_out && pwrite_in
                     && paddr_in == dsr_pkg::OFS_CLR && pwdata_in[0]) begin
            held_r <= 7'h00;
        end else if (lv) begin
            held_r <= held_r | prdata_out[6:0];
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_zero_wait: assert property (psel_in && !penable_in && ce_in
        |=> pready_out) else $error("ready missing after setup");
    a_unmapped_err: assert property (psel_in && penable_in && pready_out
        && !mapped |-> pslverr_out && prdata_out == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_mapped_ok: assert property (pready_out && mapped |-> !pslverr_out)
        else $error("error on mapped register");
    a_meas_byte: assert property (sd && ptr_r == 8'h00
        |-> prdata_out[7:0] == exp[95:88]) else $error("bad status byte 0");
    a_buf_clamp: assert property (sd && ptr_r == 8'h01
        |-> prdata_out[7:0] == exp[87:80]) else $error("bad buffer byte");
    a_status_body: assert property (sd && ptr_r > 8'h01
        && ptr_r != 8'h07 |-> prdata_out[7:0] == ((ptr_r < 8'h0c)
        ? exp[8*(11-ptr_r) +: 8] : 8'h00)) else $error("bad status byte");
    a_latch_hold: assert property (lv
        |-> (prdata_out[6:0] & held_r) == held_r)
        else $error("latched fault lost");
    a_agc_pass: assert property (lv && $stable(fault_pin_in.a1)
        && $past(fault_pin_in.a1, 6) == fault_pin_in.a1
        |-> prdata_out[7] == fault_pin_in.a1[7]
        && (prdata_out[6:0] & fault_pin_in.a1[6:0]) == fault_pin_in.a1[6:0])
        else $error("alarm byte 1 does not follow pins");
    c_status: cover property (sd && ptr_r == 8'h0b);
    c_held: cover property (lv && held_r != 7'h00);
    c_err: cover property (pslverr_out);
endmodule // dsr_reporter_checker

bind dsr_reporter dsr_reporter_checker u_chk (.clk_in, .rstn_in, .ce_in,
    .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .status_in,
    .fault_pin_in, .prdata_out, .pready_out, .pslverr_out);

// ### tb/dsr_host.sv
// Purpose: Host-side APB master that issues queries to the reporter.
// Assumes: The slave's pready ends each access phase.
// Notes:   Each call waits an edge first, so calls never collide.
`timescale 1ns/1ps
module dsr_host (
    input  wire logic        clk_in,      // Clock.
    input  wire logic [31:0] prdata_in,   // Read data.
    input  wire logic        pready_in,   // Ready.
    input  wire logic        pslverr_in,  // Error.
    output logic             psel_out,    // Select.
    output logic             penable_out, // Access phase.
    output logic             pwrite_out,  // Write.
    output logic [7:0]       paddr_out,   // Address.
    output logic [31:0]      pwdata_out   // Write data.
);
    initial begin
        psel_out    = 1'b0;
        penable_out = 1'b0;
        pwrite_out  = 1'b0;
        paddr_out   = 8'h00;
        pwdata_out  = 32'h0000_0000;
    end
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q,
                        output logic e, output logic to);
        int n;
        n = 0;
        @(posedge clk_in);
        psel_out   <= 1'b1;
        pwrite_out <= w;
        paddr_out  <= a;
        pwdata_out <= d;
        @(posedge clk_in);
        penable_out <= 1'b1;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready_in !== 1'b1 && n < 64);
        to = pready_in !== 1'b1;
        q  = prdata_in;
        e  = pslverr_in;
        psel_out    <= 1'b0;
        penable_out <= 1'b0;
        // Released lines show a changed value so stale data is not reused.
        paddr_out   <= ~a;
        pwdata_out  <= ~d;
    endtask
    task automatic query(input logic [15:0] op, output logic to);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, dsr_pkg::OFS_CMD, {16'h0000, op}, q, e, to);
    endtask
endmodule // dsr_host

// ### tb/demod_status_alarm_reporter_test.sv
// Purpose: Directed test of the status and alarm reporter over APB.
// Assumes: Fault pins pass a two-stage synchroniser.
// Notes:   Pins are held seven cycles so every latch sees them.
`timescale 1ns/1ps
module demod_status_alarm_reporter_test;
    logic                 clk_in = 1'b0;
    logic                 rstn_in;
    logic                 psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]           paddr;
    logic [31:0]          pwdata, prdata, q, b7;
    dsr_pkg::dsr_status_s status;
    dsr_pkg::dsr_alarm_s  fault;
    int                   fails = 0;
    int                   n_tests = 0;
    always #5 clk_in = ~clk_in;
    dsr_host host (.clk_in(clk_in), .prdata_in(prdata), .pready_in(pready),
        .pslverr_in(pslverr), .psel_out(psel), .penable_out(penable),
        .pwrite_out(pwrite), .paddr_out(paddr), .pwdata_out(pwdata));
    dsr_reporter DUT (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(1'b1),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite),
        .paddr_in(paddr), .pwdata_in(pwdata), .status_in(status),
        .fault_pin_in(fault), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr));
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic hung(input logic to);
        if (to) begin
            fails++;
            final_report();
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        logic to;
        host.xfer(w, a, d, q, err, to);
        hung(to);
    endtask
    task automatic resp(input logic [15:0] op, input logic [55:0] e,
                        input int n, input int len);
        logic to;
        host.query(op, to);
        hung(to);
        bus(1'b0, dsr_pkg::OFS_STAT, 32'h0);
        chk("stat", {16'h0000, len[7:0], 8'h01}, q);
        for (int i = 0; i < len; i++) begin
            bus(1'b0, dsr_pkg::OFS_DATA, 32'h0);
            if (i < n) chk("byte", {24'h0, e[55-8*i -: 8]}, q);
            if (i == 7) b7 = q;
        end
        bus(1'b0, dsr_pkg::OFS_STAT, 32'h0);
        chk("done", 32'h0, {31'h0, q[0]});
    endtask
    task automatic pins(input dsr_pkg::dsr_alarm_s f);
        fault <= f;
        repeat (7) @(posedge clk_in);
    endtask
    initial begin
        rstn_in = 1'b0;
        status  = '0;
        fault   = '0;
        repeat (2) @(posedge clk_in);
        rstn_in <= 1'b1;
        bus(1'b0, dsr_pkg::OFS_STAT, 32'h0);
        chk("stat reset", 32'h0, q);
        bus(1'b0, dsr_pkg::OFS_CTRL, 32'h0);
        chk("ctrl reset", 32'h0, q);
        status <= {6'h2a, 8'hc8, 8'h2a, 8'ha5, 6'h2a, 32'h0102_0304};
        resp(dsr_pkg::OP_STATUS, 56'h19_64_2a_a5_01_00_05, 7, 89);
        for (int e = 0; e < 4; e++) begin
            status.ebno_qual              <= e[1:0];
            status.online                 <= e[0];
            status.tp_ber_valid           <= e[0];
            status.tp_ber_ovf             <= e[1];
            status.insert_data_input_loss <= e[1];
            status.buf_pct                <= 8'h62 + 8'(e);
            resp(dsr_pkg::OP_STATUS, {2'b00, e[1], 1'b1, e[1:0], e[0], 1'b1,
                 (e < 3) ? 8'h62 + 8'(e) : 8'h64, 16'h2a_a5, 7'h00, e[0],
                 7'h00, e[1], 8'h00}, 6, 89);
        end
        pins({8'h81, 8'h80, 8'h89, 8'h11, 8'h04, 8'h09});
        resp(dsr_pkg::OP_LATCHED, 56'h81_80_89_11_04_09_00, 6, 6);
        bus(1'b1, dsr_pkg::OFS_CLR, 32'h1);
        bus(1'b0, dsr_pkg::OFS_LIVE, 32'h0);
        chk("clear while set", 32'h81, q);
        pins('0);
        resp(dsr_pkg::OP_LATCHED, 56'h01_80_81_11_04_08_00, 6, 6);
        resp(dsr_pkg::OP_LATCHED, 56'h01_80_81_11_04_08_00, 6, 6);
        resp(dsr_pkg::OP_STATUS, 56'h3f_64_2a_a5_01_01_05, 7, 89);
        chk("status alarm 4", 32'h08, b7);
        bus(1'b1, dsr_pkg::OFS_CLR, 32'h3f);
        resp(dsr_pkg::OP_LATCHED, 56'h0, 6, 6);
        resp(dsr_pkg::OP_CURRENT, 56'h40_00_ff_3f_a5_00_06, 7, 7);
        bus(1'b1, dsr_pkg::OFS_CTRL, 32'h1);
        pins({32'h0, 8'h02, 8'h02});
        resp(dsr_pkg::OP_LATCHED, 56'h0, 6, 6);
        resp(dsr_pkg::OP_CURRENT, 56'h40_00_ff_0d_a5_00_04, 7, 7);
        bus(1'b0, 8'h18, 32'h0);
        chk("unmapped", 32'h1, {31'h0, err});
        bus(1'b1, dsr_pkg::OFS_CMD, 32'h0000_1234);
        bus(1'b0, dsr_pkg::OFS_STAT, 32'h0);
        chk("bad opcode", 32'h2, {30'h0, q[1:0]});
        bus(1'b0, dsr_pkg::OFS_DATA, 32'h0);
        chk("no data", 32'h0, q);
        final_report();
    end
endmodule // demod_status_alarm_reporter_test
